// ---- logic/serial_host_ctrl.sv ----
`timescale 1ns/1ps
module serial_host_ctrl (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  serial_link_if.host link
);
  import serial_pkg::*;

  typedef struct packed {
    logic [2:0] ctrl;
    logic [6:0] reg_addr;
    logic rd;
    logic [1:0] last;
    logic [31:0] wbuf;
    logic [31:0] rbuf;
    logic busy;
    logic nack;
    logic [1:0] istat;
    logic [1:0] imask;
    serial_pkg::host_state_type st;
    logic [1:0] ph;
    logic [3:0] div;
    logic [3:0] bit_i;
    logic [1:0] stp;
    logic [1:0] didx;
    logic [7:0] sh;
    logic cs_n;
    logic mosi;
    logic sel_pin;
    logic cs_pin;
    logic mosi_pin;
    logic clk_o;
    logic clk_oe_n;
    logic data_oe_n;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } host_reg_type;

  host_reg_type h_r;
  host_reg_type h_nxt;
  logic [1:0] lv;
  logic [1:0] ev;
  logic [1:0] nd;
  logic tick;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == H_CTRL_OFS) || (a == H_CMD_OFS) || (a == H_WDATA_OFS) ||
              (a == H_RDATA_OFS) || (a == H_STAT_OFS) ||
              (a == H_ISTAT_OFS) || (a == H_IMASK_OFS);
  endfunction : reg_hit

  pin_sampler #(.W(2)) u_pins (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pins({link.irq_pin, link.two_wire_data_pin}),
    .level(lv),
    .rise(),
    .fall()
  );

  always_comb begin
    h_nxt = h_r;
    ev = '0;
    nd = '0;
    tick = h_r.busy && (h_r.div == QTR_LAST);
    h_nxt.pready = psel && !penable;
    if (psel && !penable) begin
      h_nxt.pslverr = !reg_hit(paddr);
      if (paddr == H_CTRL_OFS) begin
        h_nxt.prdata = {29'h0, h_r.ctrl};
      end else if (paddr == H_CMD_OFS) begin
        h_nxt.prdata = {21'h0, h_r.last, h_r.rd, 1'b0, h_r.reg_addr};
      end else if (paddr == H_WDATA_OFS) begin
        h_nxt.prdata = h_r.wbuf;
      end else if (paddr == H_RDATA_OFS) begin
        h_nxt.prdata = h_r.rbuf;
      end else if (paddr == H_STAT_OFS) begin
        h_nxt.prdata = {29'h0, lv[1], h_r.nack, h_r.busy};
      end else if (paddr == H_ISTAT_OFS) begin
        h_nxt.prdata = {30'h0, h_r.istat};
      end else if (paddr == H_IMASK_OFS) begin
        h_nxt.prdata = {30'h0, h_r.imask};
      end else begin
        h_nxt.prdata = '0;
      end
    end
    h_nxt.div = tick ? 4'h0 : (h_r.busy ? h_r.div + 4'h1 : 4'h0);
    if (tick) begin
      h_nxt.ph = h_r.ph + 2'h1;
      case (h_r.st)
        H_SPI: begin
          case (h_r.ph)
            2'h0: h_nxt.mosi = h_r.sh[7];
            2'h1: h_nxt.clk_o = 1'b1;
            2'h2: h_nxt.sh = {h_r.sh[6:0], lv[0]};
            default: begin
              h_nxt.clk_o = 1'b0;
              h_nxt.bit_i = h_r.bit_i + 4'h1;
              if (h_r.bit_i == 4'h7) begin
                h_nxt.bit_i = '0;
                h_nxt.stp = 2'h1;
                nd = (h_r.stp == 2'h0) ? 2'h0 : h_r.didx + 2'h1;
                h_nxt.didx = nd;
                h_nxt.sh = h_r.rd ? 8'h00 : h_r.wbuf[{nd, 3'h0} +: 8];
                if (h_r.stp != 2'h0) begin
                  if (h_r.rd) begin
                    h_nxt.rbuf[{h_r.didx, 3'h0} +: 8] = h_r.sh;
                  end
                  if (h_r.didx == h_r.last) begin
                    h_nxt.st = H_IDLE;
                    h_nxt.busy = 1'b0;
                    h_nxt.cs_n = 1'b1;
                    ev[0] = 1'b1;
                  end
                end
              end
            end
          endcase
        end
        H_START: begin
          case (h_r.ph)
            2'h0: h_nxt.data_oe_n = 1'b1;
            2'h1: h_nxt.clk_oe_n = 1'b1;
            2'h2: h_nxt.data_oe_n = 1'b0;
            default: begin
              h_nxt.clk_oe_n = 1'b0;
              h_nxt.st = H_WBIT;
              h_nxt.bit_i = '0;
              h_nxt.sh = {h_r.ctrl[1], DEV_ADDR_FIXED, h_r.stp == 2'h2};
            end
          endcase
        end
        H_WBIT, H_RBIT: begin
          case (h_r.ph)
            2'h0: begin
              if (h_r.bit_i == 4'h8) begin
                h_nxt.data_oe_n = (h_r.st == H_WBIT) || (h_r.didx == h_r.last);
              end else begin
                h_nxt.data_oe_n = (h_r.st == H_RBIT) || h_r.sh[7];
              end
            end
            2'h1: h_nxt.clk_oe_n = 1'b1;
            2'h2: begin
              if (h_r.bit_i == 4'h8) begin
                h_nxt.nack = (h_r.st == H_WBIT) && lv[0];
              end else begin
                h_nxt.sh = {h_r.sh[6:0], lv[0]};
              end
            end
            default: begin
              h_nxt.clk_oe_n = 1'b0;
              h_nxt.bit_i = h_r.bit_i + 4'h1;
              if (h_r.bit_i == 4'h8) begin
                h_nxt.bit_i = '0;
                if (h_r.st == H_RBIT) begin
                  h_nxt.rbuf[{h_r.didx, 3'h0} +: 8] = h_r.sh;
                  if (h_r.didx == h_r.last) begin
                    h_nxt.st = H_STOP;
                  end else begin
                    h_nxt.didx = h_r.didx + 2'h1;
                  end
                end else if (h_r.nack) begin
                  h_nxt.st = H_STOP;
                  ev[1] = 1'b1;
                end else if (h_r.stp == 2'h0) begin
                  h_nxt.stp = 2'h1;
                  h_nxt.sh = {1'b0, h_r.reg_addr};
                end else if (h_r.stp == 2'h1) begin
                  h_nxt.stp = 2'h2;
                  h_nxt.didx = '0;
                  h_nxt.sh = h_r.wbuf[7:0];
                  if (h_r.rd) begin
                    h_nxt.st = H_START;
                  end
                end else if (h_r.rd) begin
                  h_nxt.st = H_RBIT;
                end else if (h_r.didx == h_r.last) begin
                  h_nxt.st = H_STOP;
                end else begin
                  h_nxt.didx = h_r.didx + 2'h1;
                  h_nxt.sh = h_r.wbuf[{h_r.didx + 2'h1, 3'h0} +: 8];
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (h_r.ph)
            2'h0: h_nxt.data_oe_n = 1'b0;
            2'h1: h_nxt.clk_oe_n = 1'b1;
            2'h2: h_nxt.data_oe_n = 1'b1;
            default: begin
              h_nxt.st = H_IDLE;
              h_nxt.busy = 1'b0;
              ev[0] = 1'b1;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
    if (psel && penable && h_r.pready && pwrite) begin
      if (paddr == H_CTRL_OFS) begin
        h_nxt.ctrl = pwdata[2:0];
      end else if (paddr == H_WDATA_OFS) begin
        h_nxt.wbuf = pwdata;
      end else if (paddr == H_ISTAT_OFS) begin
        h_nxt.istat = h_r.istat & ~pwdata[1:0];
      end else if (paddr == H_IMASK_OFS) begin
        h_nxt.imask = pwdata[1:0];
      end else if (paddr == H_CMD_OFS && !h_r.busy) begin
        h_nxt.reg_addr = pwdata[6:0];
        h_nxt.rd = pwdata[CMD_READ_BIT];
        h_nxt.last = pwdata[CMD_LAST_LSB +: 2];
        h_nxt.busy = 1'b1;
        h_nxt.nack = 1'b0;
        h_nxt.ph = '0;
        h_nxt.bit_i = '0;
        h_nxt.stp = '0;
        h_nxt.didx = '0;
        h_nxt.st = h_r.ctrl[0] ? H_START : H_SPI;
        h_nxt.cs_n = h_r.ctrl[0];
        h_nxt.sh = {pwdata[CMD_READ_BIT], pwdata[6:0]};
      end
    end
    // events set after any clear, so a coincident event survives
    h_nxt.istat = h_nxt.istat | ev;
    if (h_nxt.st == H_IDLE) begin
      h_nxt.clk_oe_n = h_nxt.ctrl[0];
      h_nxt.clk_o = 1'b0;
      h_nxt.data_oe_n = 1'b1;
    end
    h_nxt.sel_pin = h_nxt.ctrl[0];
    h_nxt.cs_pin = h_nxt.ctrl[0] ? h_nxt.ctrl[1] : h_nxt.cs_n;
    h_nxt.mosi_pin = h_nxt.ctrl[0] ? h_nxt.ctrl[2] : h_nxt.mosi;
    h_nxt.irq = |(h_r.istat & h_r.imask);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      h_r <= '0;
      h_r.cs_n <= 1'b1;
      h_r.cs_pin <= 1'b1;
      h_r.data_oe_n <= 1'b1;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign prdata = h_r.prdata;
  assign pready = h_r.pready;
  assign pslverr = h_r.pslverr;
  assign irq = h_r.irq;
  assign link.two_wire_select = h_r.sel_pin;
  assign link.cs_n_or_addr_pin = h_r.cs_pin;
  assign link.data_in_or_dd2_pin = h_r.mosi_pin;
  assign link.host_clk_o = h_r.clk_o;
  assign link.host_clk_oe_n = h_r.clk_oe_n;
  assign link.host_data_o = 1'b0;
  assign link.host_data_oe_n = h_r.data_oe_n;
endmodule : serial_host_ctrl

// ---- logic/serial_pkg.sv ----
package serial_pkg;

  // link clock timing: the host divides clk_sys into quarter-bit ticks
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam int QTR_CYC = LINK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [3:0] QTR_LAST = 4'(QTR_CYC - 1);

  // cycles after reset release before straps and pins are trusted
  localparam logic [1:0] SETTLE_LAST = 2'h3;

  // device register space
  localparam logic [6:0] LINK_MODE_ADDR = 7'h1a;
  localparam logic [6:0] DIRECT_LEVELS_ADDR = 7'h75;
  localparam logic [6:0] IRQ_STATUS_ADDR = 7'h7e;
  localparam logic [6:0] IRQ_MASK_ADDR = 7'h7f;
  localparam int MIRROR_BIT = 3;
  localparam int EV_DONE_BIT = 3;
  localparam logic [7:0] DEV_REG_RESET = 8'h00;
  // arbitrary value for the fixed part of the 2-wire device address
  localparam logic [5:0] DEV_ADDR_FIXED = 6'h15;

  // pin positions inside the device input synchroniser
  localparam int P_SEL = 0;
  localparam int P_CS = 1;
  localparam int P_CLK = 2;
  localparam int P_MOSI = 3;
  localparam int P_DATA = 4;
  localparam int P_DD0 = 5;
  localparam int P_DD1 = 6;
  localparam int DEV_PINS = 7;

  // 2-wire byte roles
  localparam logic [1:0] KIND_ADDR = 2'h0;
  localparam logic [1:0] KIND_REG = 2'h1;
  localparam logic [1:0] KIND_DATA = 2'h2;

  // host controller APB map
  localparam logic [7:0] H_CTRL_OFS = 8'h00;
  localparam logic [7:0] H_CMD_OFS = 8'h04;
  localparam logic [7:0] H_WDATA_OFS = 8'h08;
  localparam logic [7:0] H_RDATA_OFS = 8'h0c;
  localparam logic [7:0] H_STAT_OFS = 8'h10;
  localparam logic [7:0] H_ISTAT_OFS = 8'h14;
  localparam logic [7:0] H_IMASK_OFS = 8'h18;
  localparam int CMD_READ_BIT = 8;
  localparam int CMD_LAST_LSB = 9;

  typedef enum logic [2:0] {
    TW_IDLE, TW_RX, TW_ACK, TW_TX, TW_RACK
  } tw_state_type;

  typedef enum logic [2:0] {
    H_IDLE, H_START, H_WBIT, H_RBIT, H_STOP, H_SPI
  } host_state_type;

endpackage : serial_pkg

// ---- logic/serial_link_if.sv ----
`timescale 1ns/1ps
interface serial_link_if;
  logic two_wire_select;
  logic cs_n_or_addr_pin;
  logic data_in_or_dd2_pin;
  logic host_clk_o;
  logic host_clk_oe_n;
  logic host_data_o;
  logic host_data_oe_n;
  logic dev_data_o;
  logic dev_data_oe_n;
  logic irq_pin;
  wire two_wire_clock_pin;
  wire two_wire_data_pin;

  // pulled-up wires; a driver pulls low only while its enable is low
  assign two_wire_clock_pin = host_clk_oe_n | host_clk_o;
  assign two_wire_data_pin = (host_data_oe_n | host_data_o) &
                             (dev_data_oe_n | dev_data_o);

  modport device (
    input two_wire_select, cs_n_or_addr_pin, data_in_or_dd2_pin,
    input two_wire_clock_pin, two_wire_data_pin,
    output dev_data_o, dev_data_oe_n, irq_pin
  );

  modport host (
    output two_wire_select, cs_n_or_addr_pin, data_in_or_dd2_pin,
    output host_clk_o, host_clk_oe_n, host_data_o, host_data_oe_n,
    input two_wire_clock_pin, two_wire_data_pin, irq_pin
  );
endinterface : serial_link_if

// ---- logic/pin_sampler.sv ----
`timescale 1ns/1ps
module pin_sampler #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] pins,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  import serial_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } sampler_type;

  sampler_type smp_r;
  sampler_type smp_nxt;

  always_comb begin
    smp_nxt.meta = pins;
    smp_nxt.sync = smp_r.meta;
    smp_nxt.prev = smp_r.sync;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      smp_r <= '0;
    end else begin
      smp_r <= smp_nxt;
    end
  end

  // edges compare stage two with stage three, never the first stage
  assign level = smp_r.sync;
  assign rise = smp_r.sync & ~smp_r.prev;
  assign fall = ~smp_r.sync & smp_r.prev;
endmodule : pin_sampler

// ---- logic/serial_slave_reg_access.sv ----
`timescale 1ns/1ps
module serial_slave_reg_access (
  input wire logic clk_sys,
  input wire logic reset_n,
  serial_link_if.device link,
  input wire logic [1:0] direct_input_pins,
  output logic [2:0] mirror_outputs
);
  import serial_pkg::*;

  typedef struct packed {
    logic [127:0][7:0] regs;
    logic [1:0] settle;
    logic ready;
    logic strap;
    logic [7:0] rx_sh;
    logic [7:0] tx_sh;
    logic [3:0] cnt;
    logic [6:0] ptr;
    logic cmd_seen;
    logic rd;
    tw_state_type tw;
    logic [1:0] kind;
    logic mack;
    logic [2:0] dd_prev;
    logic data_o;
    logic data_oe_n;
    logic irq;
    logic [2:0] mirror;
  } dev_state_type;

  dev_state_type st_r;
  dev_state_type st_nxt;
  logic [DEV_PINS-1:0] lv;
  logic [DEV_PINS-1:0] rise;
  logic [DEV_PINS-1:0] fall;
  logic two_wire;
  logic [2:0] dd_now;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] clr;
  logic [3:0] ev;
  logic [7:0] sh;
  logic [7:0] rv;
  logic load;

  // the 0x75 view is live pin state, every other address is storage
  function automatic logic [7:0] reg_read(
    input logic [127:0][7:0] regs,
    input logic [6:0] a,
    input logic [2:0] dd
  );
    if (a == DIRECT_LEVELS_ADDR) begin
      reg_read = {5'h00, dd};
    end else begin
      reg_read = regs[a];
    end
  endfunction : reg_read

  // all pins come from another clock domain
  pin_sampler #(.W(DEV_PINS)) u_pins (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pins({direct_input_pins, link.two_wire_data_pin,
           link.data_in_or_dd2_pin, link.two_wire_clock_pin,
           link.cs_n_or_addr_pin, link.two_wire_select}),
    .level(lv),
    .rise(rise),
    .fall(fall)
  );

  always_comb begin
    st_nxt = st_r;
    wr_en = 1'b0;
    wr_addr = '0;
    wr_data = '0;
    clr = '0;
    ev = '0;
    sh = '0;
    rv = '0;
    load = 1'b0;
    two_wire = lv[P_SEL];
    dd_now = {two_wire & lv[P_MOSI], lv[P_DD1], lv[P_DD0]};
    if (!st_r.ready) begin
      st_nxt.settle = st_r.settle + 2'h1;
      if (st_r.settle == SETTLE_LAST) begin
        st_nxt.ready = 1'b1;
        st_nxt.strap = lv[P_CS];
      end
    end else if (!two_wire) begin
      st_nxt.tw = TW_IDLE;
      st_nxt.data_oe_n = lv[P_CS];
      if (lv[P_CS]) begin
        st_nxt.cnt = '0;
        st_nxt.cmd_seen = 1'b0;
        st_nxt.tx_sh = '0;
        ev[EV_DONE_BIT] = rise[P_CS];
      end else begin
        if (rise[P_CLK]) begin
          sh = {st_r.rx_sh[6:0], lv[P_MOSI]};
          st_nxt.rx_sh = sh;
          st_nxt.cnt = st_r.cnt + 4'h1;
          if (st_r.cnt == 4'h7) begin
            st_nxt.cnt = '0;
            if (!st_r.cmd_seen) begin
              st_nxt.cmd_seen = 1'b1;
              st_nxt.rd = sh[7];
              st_nxt.ptr = sh[6:0];
              if (sh[7]) begin
                st_nxt.tx_sh = reg_read(st_r.regs, sh[6:0], dd_now);
                st_nxt.ptr = sh[6:0] + 7'h1;
              end
            end else if (st_r.rd) begin
              st_nxt.tx_sh = reg_read(st_r.regs, st_r.ptr, dd_now);
              st_nxt.ptr = st_r.ptr + 7'h1;
            end else begin
              wr_en = 1'b1;
              wr_addr = st_r.ptr;
              wr_data = sh;
              st_nxt.ptr = st_r.ptr + 7'h1;
            end
          end
        end
        if (fall[P_CLK]) begin
          st_nxt.data_o = st_r.tx_sh[7];
          st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
        end
      end
    end else begin
      st_nxt.data_o = 1'b0;
      // start condition restarts the byte engine
      if (lv[P_CLK] && fall[P_DATA]) begin
        st_nxt.tw = TW_RX;
        st_nxt.kind = KIND_ADDR;
        st_nxt.cnt = '0;
        st_nxt.data_oe_n = 1'b1;
      end else if (lv[P_CLK] && rise[P_DATA]) begin
        ev[EV_DONE_BIT] = (st_r.tw != TW_IDLE);
        st_nxt.tw = TW_IDLE;
        st_nxt.data_oe_n = 1'b1;
      end else begin
        case (st_r.tw)
          TW_RX: begin
            if (rise[P_CLK]) begin
              st_nxt.rx_sh = {st_r.rx_sh[6:0], lv[P_DATA]};
              st_nxt.cnt = st_r.cnt + 4'h1;
            end
            if (fall[P_CLK] && st_r.cnt == 4'h8) begin
              st_nxt.cnt = '0;
              st_nxt.tw = TW_ACK;
              st_nxt.data_oe_n = 1'b0;
              if (st_r.kind == KIND_ADDR) begin
                if (st_r.rx_sh[7:1] == {st_r.strap, DEV_ADDR_FIXED}) begin
                  st_nxt.rd = st_r.rx_sh[0];
                end else begin
                  st_nxt.tw = TW_IDLE;
                  st_nxt.data_oe_n = 1'b1;
                end
              end else if (st_r.kind == KIND_REG) begin
                st_nxt.ptr = st_r.rx_sh[6:0];
              end else begin
                wr_en = 1'b1;
                wr_addr = st_r.ptr;
                wr_data = st_r.rx_sh;
                st_nxt.ptr = st_r.ptr + 7'h1;
              end
              if (st_r.kind != KIND_DATA) begin
                st_nxt.kind = st_r.kind + 2'h1;
              end
            end
          end
          TW_ACK: begin
            if (fall[P_CLK]) begin
              if (st_r.rd) begin
                load = 1'b1;
              end else begin
                st_nxt.tw = TW_RX;
                st_nxt.data_oe_n = 1'b1;
              end
            end
          end
          TW_TX: begin
            if (fall[P_CLK]) begin
              if (st_r.cnt == 4'h8) begin
                st_nxt.data_oe_n = 1'b1;
                st_nxt.tw = TW_RACK;
              end else begin
                st_nxt.data_oe_n = st_r.tx_sh[7];
                st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
                st_nxt.cnt = st_r.cnt + 4'h1;
              end
            end
          end
          TW_RACK: begin
            if (rise[P_CLK]) begin
              st_nxt.mack = ~lv[P_DATA];
            end
            if (fall[P_CLK]) begin
              if (st_r.mack) begin
                load = 1'b1;
              end else begin
                st_nxt.tw = TW_IDLE;
              end
            end
          end
          default: begin
          end
        endcase
        if (load) begin
          rv = reg_read(st_r.regs, st_r.ptr, dd_now);
          st_nxt.data_oe_n = rv[7];
          st_nxt.tx_sh = {rv[6:0], 1'b0};
          st_nxt.cnt = 4'h1;
          st_nxt.ptr = st_r.ptr + 7'h1;
          st_nxt.tw = TW_TX;
        end
      end
    end
    if (wr_en && wr_addr == IRQ_STATUS_ADDR) begin
      clr = wr_data;
    end else if (wr_en && wr_addr != DIRECT_LEVELS_ADDR) begin
      st_nxt.regs[wr_addr] = wr_data;
    end
    if (st_r.ready) begin
      ev[2:0] = dd_now ^ st_r.dd_prev;
    end
    st_nxt.dd_prev = dd_now;
    // a new event outranks a clear in the same cycle
    st_nxt.regs[IRQ_STATUS_ADDR] =
      (st_r.regs[IRQ_STATUS_ADDR] & ~clr) | {4'h0, ev};
    st_nxt.irq = |(st_r.regs[IRQ_STATUS_ADDR] & st_r.regs[IRQ_MASK_ADDR]);
    st_nxt.mirror = st_r.regs[LINK_MODE_ADDR][MIRROR_BIT] ? dd_now : 3'h0;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
      st_r.data_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // oversampled pins keep up with the 6.25 MHz link clock
  assign link.dev_data_o = st_r.data_o;
  assign link.dev_data_oe_n = st_r.data_oe_n;
  assign link.irq_pin = st_r.irq;
  assign mirror_outputs = st_r.mirror;
endmodule : serial_slave_reg_access

// ---- bench/link_asserts.sv ----
`timescale 1ns/1ps
module link_asserts (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic two_wire_select,
  input wire logic cs_n_or_addr_pin,
  input wire logic data_in_or_dd2_pin,
  input wire logic host_clk_o,
  input wire logic host_clk_oe_n,
  input wire logic host_data_o,
  input wire logic dev_data_o,
  input wire logic dev_data_oe_n,
  input wire logic two_wire_clock_pin
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence tw_on;
    two_wire_select [*8];
  endsequence
  sequence spi_idle;
    (!two_wire_select && cs_n_or_addr_pin) [*8];
  endsequence
  sequence spi_act;
    !two_wire_select && !cs_n_or_addr_pin;
  endsequence
  chk_spi_release:
    assert property (spi_idle |-> dev_data_oe_n) else $error("spi out held");
  chk_spi_clk_idle:
    assert property (!two_wire_select && cs_n_or_addr_pin |-> !host_clk_o)
    else $error("spi clock moved while idle");
  chk_miso_timing:
    assert property (spi_act ##0 $changed(dev_data_o) |-> !two_wire_clock_pin)
    else $error("spi out changed with clock high");
  chk_mosi_stable:
    assert property (spi_act ##0 two_wire_clock_pin
      |-> $stable(data_in_or_dd2_pin)) else $error("spi in moved");
  chk_spi_push:
    assert property ((!two_wire_select) [*8] |-> !host_clk_oe_n)
    else $error("spi clock not driven");
  chk_tw_dev_od:
    assert property (tw_on |-> dev_data_oe_n || !dev_data_o)
    else $error("device drove data high");
  chk_tw_host_od:
    assert property (tw_on |-> !host_clk_o && !host_data_o)
    else $error("host drove a line high");
  chk_tw_hold:
    assert property (tw_on ##0 two_wire_clock_pin && $past(two_wire_clock_pin)
      |-> $stable(dev_data_oe_n)) else $error("data moved, clock high");
endmodule : link_asserts

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import serial_pkg::*;
  logic clk_sys = 0, reset_n = 0, dev_reset_n = 0;
  logic [7:0] paddr = 8'h0;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [31:0] pwdata = 32'h0, want = 32'h0, prdata, rd, v;
  logic [31:0] seed = 32'h13;
  logic [1:0] direct_input_pins = 2'h0;
  logic [2:0] mirror_outputs;
  logic [32:0] exp_q[$];
  int n_fail = 0, num_checks = 0;
  serial_link_if link();
  serial_host_ctrl serial_host_ctrl_inst(.clk_sys, .reset_n, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq, .link);
  serial_slave_reg_access serial_slave_reg_access_inst(.clk_sys,
    .reset_n(dev_reset_n), .link, .direct_input_pins, .mirror_outputs);
  link_asserts link_asserts_inst(.clk_sys, .reset_n(dev_reset_n),
    .two_wire_select(link.two_wire_select),
    .cs_n_or_addr_pin(link.cs_n_or_addr_pin),
    .data_in_or_dd2_pin(link.data_in_or_dd2_pin),
    .host_clk_o(link.host_clk_o), .host_clk_oe_n(link.host_clk_oe_n),
    .host_data_o(link.host_data_o), .dev_data_o(link.dev_data_o),
    .dev_data_oe_n(link.dev_data_oe_n),
    .two_wire_clock_pin(link.two_wire_clock_pin));
  always #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic results();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  task automatic expire();
    n_fail++;
    results();
  endtask : expire
  task automatic chk(input logic [32:0] g, e, input string n);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  // reads with a nonzero mask are judged against the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && pready === 1'b1 && !pwrite && want != 32'h0) begin
      chk({pslverr, prdata & want}, exp_q.pop_front(), "apb read");
    end
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, m);
    int i;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    want <= m;
    @(posedge clk_sys);
    penable <= 1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) expire();
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rdq(input logic [7:0] a, input logic [31:0] m,
                     input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, a, 32'h0, m);
  endtask : rdq
  task automatic xfer(input logic r, input logic [6:0] a,
                      input logic [1:0] n, input logic [31:0] d);
    int j;
    apb(1, H_WDATA_OFS, d, 32'h0);
    apb(1, H_CMD_OFS, {21'h0, n, r, 1'b0, a}, 32'h0);
    for (j = 0; j < 2000; j++) begin
      apb(0, H_STAT_OFS, 32'h0, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (j == 2000) expire();
  endtask : xfer
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1;
    dev_reset_n <= 1;
    repeat (8) @(posedge clk_sys);
    rdq(8'h40, 32'hffffffff, {1'b1, 32'h0});
    apb(1, H_IMASK_OFS, 32'h1, 32'h0);
    v = rnd();
    xfer(0, 7'h10, 2'h3, v);
    chk({32'h0, irq}, 33'h1, "done irq");
    apb(1, H_ISTAT_OFS, 32'h1, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({32'h0, irq}, 33'h0, "cleared irq");
    xfer(1, 7'h10, 2'h3, 32'h0);
    rdq(H_RDATA_OFS, 32'hffffffff, {1'b0, v});
    v = rnd();
    direct_input_pins <= v[1:0];
    xfer(1, DIRECT_LEVELS_ADDR, 2'h0, 32'h0);
    rdq(H_RDATA_OFS, 32'hff, {31'h0, direct_input_pins});
    xfer(0, IRQ_MASK_ADDR, 2'h0, 32'h8);
    repeat (8) @(posedge clk_sys);
    rdq(H_STAT_OFS, 32'h4, {1'b0, 32'h4});
    // strap must be on the pin before the device leaves reset
    apb(1, H_CTRL_OFS, 32'h7, 32'h0);
    dev_reset_n <= 0;
    repeat (2) @(posedge clk_sys);
    dev_reset_n <= 1;
    repeat (8) @(posedge clk_sys);
    xfer(0, LINK_MODE_ADDR, 2'h0, 32'h8);
    direct_input_pins <= ~direct_input_pins;
    repeat (8) @(posedge clk_sys);
    chk({30'h0, mirror_outputs}, {30'h0, 1'b1, direct_input_pins}, "mirror");
    v = rnd();
    xfer(0, 7'h20, 2'h3, v);
    xfer(1, 7'h20, 2'h3, 32'h0);
    rdq(H_RDATA_OFS, 32'hffffffff, {1'b0, v});
    xfer(1, DIRECT_LEVELS_ADDR, 2'h0, 32'h0);
    rdq(H_RDATA_OFS, 32'hff, {30'h0, 1'b1, direct_input_pins});
    apb(1, H_IMASK_OFS, 32'h2, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({32'h0, irq}, 33'h0, "masked irq");
    // wrong strap bit in the address byte must go unanswered
    apb(1, H_CTRL_OFS, 32'h5, 32'h0);
    xfer(1, 7'h20, 2'h0, 32'h0);
    rdq(H_STAT_OFS, 32'h2, {1'b0, 32'h2});
    chk({32'h0, irq}, 33'h1, "nack irq");
    results();
  end
endmodule : tb_top
